// ===== hdl/epiu_consts.vh
// Purpose: Constants for the external pin interrupt unit.
// Assumes: Register index times four gives the byte address.
// Notes: Definitions only.
`ifndef EPIU_CONSTS_VH
`define EPIU_CONSTS_VH

// Register indices.
`define EPIU_IDX_EIE 8'h1d
`define EPIU_IDX_PCC 8'h68
`define EPIU_IDX_MLO 8'h6b
`define EPIU_IDX_MMID 8'h6c
`define EPIU_IDX_MHI 8'h6d
`define EPIU_IDX_ESC 8'h70
`define EPIU_IDX_EFL 8'h71
`define EPIU_IDX_PCF 8'h72

// Writable bit masks; other bits read as zero.
`define EPIU_ESC_MASK 8'h0f
`define EPIU_EIE_MASK 8'h03
`define EPIU_PCC_MASK 8'h07
`define EPIU_MMID_MASK 8'h7f
`define EPIU_RESET_VAL 8'h00

// Sense field positions and codes.
`define EPIU_SENSE_A_LSB 0
`define EPIU_SENSE_B_LSB 2
`define EPIU_SENSE_LOW 2'h0
`define EPIU_SENSE_ANY 2'h1
`define EPIU_SENSE_FALL 2'h2
`define EPIU_SENSE_RISE 2'h3

// Request and acknowledge bit positions.
`define EPIU_REQ_EXT_A 0
`define EPIU_REQ_EXT_B 1
`define EPIU_REQ_GRP0 2
`define EPIU_REQ_GRP1 3
`define EPIU_REQ_GRP2 4

// Bus responses.
`define EPIU_RESP_OKAY 2'h0
`define EPIU_RESP_SLVERR 2'h2

`endif

// ===== hdl/epiu_top.v
// Purpose: External pin interrupt unit with an AXI4-Lite register slave.
// Assumes: One 20 MHz clock; pins are asynchronous and are synchronised here.
// Notes: Pin activity wakes the clock through the combinational WAKE_O path.
// How it works
// [RULE1] Pins raise requests regardless of their direction; only pin level matters.
// [RULE2] Group 2 request on any unmasked toggle of pins 23 to 16.
// [RULE3] Group 1 request on any unmasked toggle of pins 14 to 8.
// [RULE4] Group 0 request on any unmasked toggle of pins 7 to 0.
// [RULE5] Three mask registers choose which pins feed each group.
// [RULE6] Pin changes are also seen without the clock, to wake from sleep.
// [RULE7] Enabled low-level sensing requests as long as the pin is low.
// [RULE8] Edge and change sensing runs on the clock only.
// [RULE9] Low level on dedicated inputs is seen without the clock for wake.
// [RULE10] A level gone before start-up ends wakes but gives no request.
// [RULE11] Sense bits 3:2 select low, change, falling or rising for input b.
// [RULE12] Sense bits 1:0 select the same for input a.
// [RULE13] Dedicated inputs are sampled before edge detection.
// [RULE14] Source holds low level until the current instruction ends.
// [RULE15] Enable bits 1 and 0 with global enable gate inputs b and a.
// [RULE16] Dedicated edge sets flag; entry or write of one clears it.
// [RULE17] A dedicated flag reads zero while its input senses low level.
// [RULE18] Control bit 2 with global enable gates group 2.
// [RULE19] Unused register bits ignore writes and read as zero.
// [RULE20] Control bits 1 and 0 with global enable gate groups 1 and 0.
// [RULE21] Group change sets group flag; entry or write of one clears it.
// [RULE22] A set mask bit enables its pin, a clear bit disables it.
// [RULE23] Requests are flag, enable and global enable; acknowledge clears.
// [RULE24] All registers reset to zero.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "epiu_consts.vh"

module epiu_top (
  input wire CLOCK_I, // 20 MHz clock.
  input wire RESET_N_I, // Synchronous reset, active low.
  input wire [1:0] EXT_PIN_I, // Dedicated inputs, bit 0 is a.
  input wire [23:0] PC_PIN_I, // Pin-change inputs.
  input wire GIE_I, // Global interrupt enable from the status word.
  input wire [4:0] ACK_I, // One-cycle vector entry pulses.
  output wire [4:0] IRQ_O, // Request lines toward the CPU.
  output wire WAKE_O, // Clockless wake request.
  input wire [9:0] AWADDR_I, // Write address.
  input wire AWVALID_I, // Write address valid.
  output wire AWREADY_O, // Write address ready.
  input wire [31:0] WDATA_I, // Write data.
  input wire [3:0] WSTRB_I, // Write byte strobes.
  input wire WVALID_I, // Write data valid.
  output wire WREADY_O, // Write data ready.
  output wire [1:0] BRESP_O, // Write response.
  output wire BVALID_O, // Write response valid.
  input wire BREADY_I, // Write response ready.
  input wire [9:0] ARADDR_I, // Read address.
  input wire ARVALID_I, // Read address valid.
  output wire ARREADY_O, // Read address ready.
  output wire [31:0] RDATA_O, // Read data.
  output wire [1:0] RRESP_O, // Read response.
  output wire RVALID_O, // Read data valid.
  input wire RREADY_I // Read data ready.
);

  // Sense match: does an event of the filtered input fit the mode?
  function sense_hit;
    input [1:0] mode;
    input evt;
    input val;
    begin
      case (mode)
        `EPIU_SENSE_ANY: sense_hit = evt;
        `EPIU_SENSE_FALL: sense_hit = evt & ~val;
        `EPIU_SENSE_RISE: sense_hit = evt & val;
        default: sense_hit = 1'b0;
      endcase
    end
  endfunction

  // Address decode: index of an aligned word, or 8'hff when misaligned.
  function [7:0] word_idx;
    input [9:0] addr;
    begin
      if (addr[1:0] != 2'h0) begin
        word_idx = 8'hff;
      end else begin
        word_idx = addr[9:2];
      end
    end
  endfunction

  // Register map hit check.
  function is_mapped;
    input [7:0] idx;
    begin
      case (idx)
        `EPIU_IDX_EIE, `EPIU_IDX_PCC, `EPIU_IDX_MLO,
        `EPIU_IDX_MMID, `EPIU_IDX_MHI, `EPIU_IDX_ESC,
        `EPIU_IDX_EFL, `EPIU_IDX_PCF: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  reg [7:0] esc_ff;
  reg [7:0] eie_ff;
  reg [7:0] pcc_ff;
  reg [7:0] mlo_ff;
  reg [7:0] mmid_ff;
  reg [7:0] mhi_ff;
  reg [1:0] ext_flag_ff;
  reg [2:0] grp_flag_ff;
  reg [1:0] ext_s1_ff;
  reg [1:0] ext_s2_ff;
  reg [1:0] ext_s3_ff;
  reg [1:0] ext_filt_ff;
  reg [23:0] pc_s1_ff;
  reg [23:0] pc_s2_ff;
  reg [23:0] pc_s3_ff;
  reg [23:0] pc_filt_ff;
  reg aw_hold_ff;
  reg [9:0] aw_addr_ff;
  reg w_hold_ff;
  reg [7:0] w_data_ff;
  reg w_lane_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  wire [1:0] ext_evt;
  wire [1:0] nxt_ext_filt;
  wire [23:0] pc_evt;
  wire [23:0] nxt_pc_filt;
  wire [1:0] mode_a;
  wire [1:0] mode_b;
  wire [1:0] lvl_mode;
  wire [1:0] ext_set;
  wire [2:0] grp_set;
  wire [23:0] mask_all;
  wire aw_take;
  wire w_take;
  wire ar_take;
  wire do_wr;
  wire [7:0] wr_idx;
  wire wr_ok;
  wire [7:0] ar_idx;
  wire [1:0] ext_clr;
  wire [2:0] grp_clr;
  reg [1:0] nxt_ext_flag;
  reg [2:0] nxt_grp_flag;
  reg [7:0] rd_byte;

  // Three-stage synchronisers on every pin; stage one feeds only stage two.
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      ext_s1_ff <= 2'h3;
      ext_s2_ff <= 2'h3;
      ext_s3_ff <= 2'h3;
      pc_s1_ff <= 24'h000000;
      pc_s2_ff <= 24'h000000;
      pc_s3_ff <= 24'h000000;
    end else begin
      ext_s1_ff <= EXT_PIN_I; // [RULE1] [RULE13]
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      pc_s1_ff <= PC_PIN_I; // [RULE1]
      pc_s2_ff <= pc_s1_ff;
      pc_s3_ff <= pc_s2_ff;
    end
  end

  // A change counts only once stages two and three agree, which filters glitches.
  assign nxt_ext_filt = (ext_s2_ff & ~(ext_s2_ff ^ ext_s3_ff)) |
                        (ext_filt_ff & (ext_s2_ff ^ ext_s3_ff));
  assign nxt_pc_filt = (pc_s2_ff & ~(pc_s2_ff ^ pc_s3_ff)) |
                       (pc_filt_ff & (pc_s2_ff ^ pc_s3_ff));
  assign ext_evt = nxt_ext_filt ^ ext_filt_ff; // [RULE8] [RULE13]
  assign pc_evt = nxt_pc_filt ^ pc_filt_ff;

  // Filtered pin values; the idle level of the dedicated inputs is high.
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      ext_filt_ff <= 2'h3;
      pc_filt_ff <= 24'h000000;
    end else begin
      ext_filt_ff <= nxt_ext_filt;
      pc_filt_ff <= nxt_pc_filt;
    end
  end

  // Sense modes for both dedicated inputs.
  assign mode_a = esc_ff[`EPIU_SENSE_A_LSB+1:`EPIU_SENSE_A_LSB]; // [RULE12]
  assign mode_b = esc_ff[`EPIU_SENSE_B_LSB+1:`EPIU_SENSE_B_LSB]; // [RULE11]
  assign lvl_mode[0] = (mode_a == `EPIU_SENSE_LOW);
  assign lvl_mode[1] = (mode_b == `EPIU_SENSE_LOW);

  // Edge events that fit the selected sense mode set the dedicated flags.
  assign ext_set[0] = sense_hit(mode_a, ext_evt[0], nxt_ext_filt[0]); // [RULE12]
  assign ext_set[1] = sense_hit(mode_b, ext_evt[1], nxt_ext_filt[1]); // [RULE11]

  // Mask bits pick the pins of each group; bit 15 has no mask and stays out.
  assign mask_all = {mhi_ff, mmid_ff, mlo_ff}; // [RULE5] [RULE22]
  assign grp_set[2] = |(pc_evt[23:16] & mask_all[23:16]); // [RULE2]
  assign grp_set[1] = |(pc_evt[14:8] & mask_all[14:8]); // [RULE3]
  assign grp_set[0] = |(pc_evt[7:0] & mask_all[7:0]); // [RULE4]

  // Bus handshakes: one pending address and one pending data word at most.
  assign AWREADY_O = ~aw_hold_ff;
  assign WREADY_O = ~w_hold_ff;
  assign ARREADY_O = ~rvalid_ff;
  assign aw_take = AWVALID_I & ~aw_hold_ff;
  assign w_take = WVALID_I & ~w_hold_ff;
  assign ar_take = ARVALID_I & ~rvalid_ff;
  assign do_wr = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign wr_idx = word_idx(aw_addr_ff);
  assign wr_ok = is_mapped(wr_idx);
  assign ar_idx = word_idx(ARADDR_I);

  // Write-one-to-clear for flags; vector entry clears the serviced flag.
  assign ext_clr[0] = (do_wr & w_lane_ff & (wr_idx == `EPIU_IDX_EFL) & w_data_ff[0]) |
                      ACK_I[`EPIU_REQ_EXT_A];
  assign ext_clr[1] = (do_wr & w_lane_ff & (wr_idx == `EPIU_IDX_EFL) & w_data_ff[1]) |
                      ACK_I[`EPIU_REQ_EXT_B];
  assign grp_clr = ({3{do_wr & w_lane_ff & (wr_idx == `EPIU_IDX_PCF)}} & w_data_ff[2:0]) |
                   ACK_I[`EPIU_REQ_GRP2:`EPIU_REQ_GRP0];

  // Flag update: a set wins over a clear, but level mode forces zero.
  always @* begin
    nxt_ext_flag = (ext_flag_ff & ~ext_clr) | ext_set; // [RULE16]
    nxt_ext_flag = nxt_ext_flag & ~lvl_mode; // [RULE17]
    nxt_grp_flag = (grp_flag_ff & ~grp_clr) | grp_set; // [RULE21]
  end

  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      ext_flag_ff <= 2'h0; // [RULE24]
      grp_flag_ff <= 3'h0;
    end else begin
      ext_flag_ff <= nxt_ext_flag;
      grp_flag_ff <= nxt_grp_flag;
    end
  end

  // Control register writes keep only the implemented bits.
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      esc_ff <= `EPIU_RESET_VAL; // [RULE24]
      eie_ff <= `EPIU_RESET_VAL;
      pcc_ff <= `EPIU_RESET_VAL;
      mlo_ff <= `EPIU_RESET_VAL;
      mmid_ff <= `EPIU_RESET_VAL;
      mhi_ff <= `EPIU_RESET_VAL;
    end else if (do_wr & w_lane_ff) begin
      case (wr_idx)
        `EPIU_IDX_ESC: esc_ff <= w_data_ff & `EPIU_ESC_MASK; // [RULE19]
        `EPIU_IDX_EIE: eie_ff <= w_data_ff & `EPIU_EIE_MASK; // [RULE19]
        `EPIU_IDX_PCC: pcc_ff <= w_data_ff & `EPIU_PCC_MASK; // [RULE19]
        `EPIU_IDX_MLO: mlo_ff <= w_data_ff;
        `EPIU_IDX_MMID: mmid_ff <= w_data_ff & `EPIU_MMID_MASK;
        `EPIU_IDX_MHI: mhi_ff <= w_data_ff;
        default: mlo_ff <= mlo_ff;
      endcase
    end
  end

  // Write channel capture in either order, then one response.
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 10'h000;
      w_hold_ff <= 1'b0;
      w_data_ff <= 8'h00;
      w_lane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `EPIU_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= AWADDR_I;
      end
      if (w_take) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= WDATA_I[7:0];
        w_lane_ff <= WSTRB_I[0];
      end
      if (do_wr) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? `EPIU_RESP_OKAY : `EPIU_RESP_SLVERR;
      end else if (bvalid_ff & BREADY_I) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read mux; reserved bits are never stored, so they read as zero.
  always @* begin
    case (ar_idx)
      `EPIU_IDX_ESC: rd_byte = esc_ff;
      `EPIU_IDX_EIE: rd_byte = eie_ff;
      `EPIU_IDX_PCC: rd_byte = pcc_ff;
      `EPIU_IDX_EFL: rd_byte = {6'h00, ext_flag_ff}; // [RULE19]
      `EPIU_IDX_PCF: rd_byte = {5'h00, grp_flag_ff}; // [RULE19]
      `EPIU_IDX_MLO: rd_byte = mlo_ff;
      `EPIU_IDX_MMID: rd_byte = mmid_ff;
      `EPIU_IDX_MHI: rd_byte = mhi_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  // Read answer one cycle after the address is taken.
  always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `EPIU_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h000000, rd_byte};
      rresp_ff <= is_mapped(ar_idx) ? `EPIU_RESP_OKAY : `EPIU_RESP_SLVERR;
    end else if (rvalid_ff & RREADY_I) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign BVALID_O = bvalid_ff;
  assign BRESP_O = bresp_ff;
  assign RVALID_O = rvalid_ff;
  assign RDATA_O = rdata_ff;
  assign RRESP_O = rresp_ff;

  // Level mode requests straight from the filtered low level, so a short
  // low that ends early leaves no request behind.
  assign IRQ_O[`EPIU_REQ_EXT_A] = GIE_I & eie_ff[0] &
    (lvl_mode[0] ? ~ext_filt_ff[0] : ext_flag_ff[0]); // [RULE7] [RULE10] [RULE15]
  assign IRQ_O[`EPIU_REQ_EXT_B] = GIE_I & eie_ff[1] &
    (lvl_mode[1] ? ~ext_filt_ff[1] : ext_flag_ff[1]); // [RULE7] [RULE15]
  assign IRQ_O[`EPIU_REQ_GRP2] = GIE_I & pcc_ff[2] & grp_flag_ff[2]; // [RULE18] [RULE23]
  assign IRQ_O[`EPIU_REQ_GRP1] = GIE_I & pcc_ff[1] & grp_flag_ff[1]; // [RULE20] [RULE23]
  assign IRQ_O[`EPIU_REQ_GRP0] = GIE_I & pcc_ff[0] & grp_flag_ff[0]; // [RULE20] [RULE23]

  // Clockless wake path: raw pins against the last filtered value, so it
  // works with the clock stopped; it may glitch, which only costs a wake.
  assign WAKE_O = (|((PC_PIN_I ^ pc_filt_ff) & mask_all &
                    {pcc_ff[2], {8{1'b0}}, 15'h0000} )) |
                  (|((PC_PIN_I[23:16] ^ pc_filt_ff[23:16]) & mhi_ff & {8{pcc_ff[2]}})) |
                  (|((PC_PIN_I[14:8] ^ pc_filt_ff[14:8]) & mmid_ff[6:0] & {7{pcc_ff[1]}})) |
                  (|((PC_PIN_I[7:0] ^ pc_filt_ff[7:0]) & mlo_ff & {8{pcc_ff[0]}})) | // [RULE6]
                  (|(~EXT_PIN_I & eie_ff[1:0] & lvl_mode)); // [RULE9]

endmodule
`default_nettype wire

// ===== verif/epiu_chk_sva.sv
// Purpose: Port-level checks for the external pin interrupt unit.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Pin history lives in helper flops so an ack is judged only when no set can race it.
`timescale 1ns/1ps
`default_nettype none
module epiu_chk (
  input wire logic CLOCK_I, // Clock.
  input wire logic RESET_N_I, // Reset, active low.
  input wire logic [23:0] PC_PIN_I, // Pin-change inputs.
  input wire logic GIE_I, // Global enable.
  input wire logic [4:0] ACK_I, // Vector entry pulses.
  input wire logic [4:0] IRQ_O, // Request lines.
  input wire logic AWVALID_I, // Write address valid.
  input wire logic AWREADY_O, // Write address ready.
  input wire logic WVALID_I, // Write data valid.
  input wire logic WREADY_O, // Write data ready.
  input wire logic BVALID_O, // Write response valid.
  input wire logic BREADY_I, // Write response ready.
  input wire logic ARVALID_I, // Read address valid.
  input wire logic ARREADY_O, // Read address ready.
  input wire logic RVALID_O, // Read data valid.
  input wire logic RREADY_I, // Read data ready.
  input wire logic [31:0] RDATA_O // Read data.
);
  logic [23:0] pc_d1_ff, pc_d2_ff, pc_d3_ff, pc_d4_ff;
  wire pc_quiet = (PC_PIN_I == pc_d1_ff) && (pc_d1_ff == pc_d2_ff) &&
    (pc_d2_ff == pc_d3_ff) && (pc_d3_ff == pc_d4_ff);
  // Four cycles of pin history cover synchroniser and filter, so no flag set is in flight.
  always @(posedge CLOCK_I) begin
    pc_d1_ff <= PC_PIN_I;
    pc_d2_ff <= pc_d1_ff;
    pc_d3_ff <= pc_d2_ff;
    pc_d4_ff <= pc_d3_ff;
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  // A write is taken whole in one cycle, then answered one quiet cycle later.
  sequence wr_taken;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  sequence wr_answer;
    !BVALID_O ##1 BVALID_O;
  endsequence
  gie_gate_a: assert property (!GIE_I |-> IRQ_O == 5'h00)
    else $error("Request raised without global enable.");
  ack_clear_a: assert property (ACK_I[2] && pc_quiet |=> !IRQ_O[2])
    else $error("Acknowledge did not clear the group request.");
  wr_latency_a: assert property (wr_taken |=> wr_answer)
    else $error("Write response not on time.");
  aw_block_a: assert property (AWVALID_I && AWREADY_O |=> !AWREADY_O)
    else $error("Second write address accepted while one is pending.");
  bvalid_end_a: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
    else $error("Write response not released.");
  rd_latency_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("Read data not on time.");
  ar_block_a: assert property (RVALID_O |-> !ARREADY_O)
    else $error("Read address accepted while data waits.");
  rvalid_end_a: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
    else $error("Read data not released.");
  rdata_zero_a: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h000000)
    else $error("Upper read data bits not zero.");
endmodule
`default_nettype wire

// ===== verif/epiu_pin_src.sv
// Purpose: Model of the outside circuitry that drives the interrupt pins.
// Assumes: The bench commands the levels; the model moves them after a clock edge.
// Notes: Levels hold until commanded otherwise, so every pulse outlasts the filter.
`timescale 1ns/1ps
`default_nettype none
module epiu_pin_src (
  input wire logic clk_i, // Clock.
  input wire logic [1:0] ext_cmd_i, // Wanted dedicated levels.
  input wire logic [23:0] pc_cmd_i, // Wanted pin-change levels.
  output logic [1:0] ext_pin_o, // Dedicated pin levels.
  output logic [23:0] pc_pin_o // Pin-change levels.
);
  // Idle levels at time zero; dedicated inputs rest high so no false falling edge.
  initial begin
    ext_pin_o = 2'h3;
    pc_pin_o = 24'h000000;
  end
  // A shorter pulse could vanish in the synchroniser, so levels never change faster.
  always @(posedge clk_i) begin
    ext_pin_o <= ext_cmd_i;
    pc_pin_o <= pc_cmd_i;
  end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Purpose: Self-checking bench for the external pin interrupt unit.
// Assumes: AXI4-Lite master tasks; pins driven through the source model.
// Notes: Waits after pin moves are fixed because flags settle three edges after sampling.
`timescale 1ns/1ps
`default_nettype none
`include "epiu_consts.vh"
module tb;
  logic clock = 1'b0, reset_n = 1'b0, gie = 1'b0, e;
  logic [4:0] ack = 5'h00;
  logic [1:0] ext_cmd = 2'h3;
  logic [23:0] pc_cmd = 24'h000000;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  wire [1:0] ext_pin, bresp, rresp;
  wire [23:0] pc_pin;
  wire [4:0] irq;
  wire awready, wready, bvalid, arready, rvalid, wake;
  wire [31:0] rdata;
  int errors = 0, comparisons = 0;
  logic [7:0] idx_tab [8] = '{`EPIU_IDX_ESC, `EPIU_IDX_EIE, `EPIU_IDX_PCC, `EPIU_IDX_MLO,
    `EPIU_IDX_MMID, `EPIU_IDX_MHI, `EPIU_IDX_EFL, `EPIU_IDX_PCF};
  logic [7:0] mask_tab [8] = '{8'h0f, 8'h03, 8'h07, 8'hff, 8'h7f, 8'hff, 8'h00, 8'h00};
  logic [23:0] pin_tab [4] = '{24'h000002, 24'h000001, 24'h000100, 24'h800000};
  logic [4:0] irq_tab [4] = '{5'h00, 5'h04, 5'h08, 5'h10};
  epiu_pin_src src (.clk_i(clock), .ext_cmd_i(ext_cmd), .pc_cmd_i(pc_cmd),
    .ext_pin_o(ext_pin), .pc_pin_o(pc_pin));
  epiu_top dut (.CLOCK_I(clock), .RESET_N_I(reset_n), .EXT_PIN_I(ext_pin), .PC_PIN_I(pc_pin),
    .GIE_I(gie), .ACK_I(ack), .IRQ_O(irq), .WAKE_O(wake), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
    .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready));
  // Free-running 20 MHz clock.
  initial begin
    forever #25 clock = ~clock;
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic [4:0] got, input logic [4:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t irq got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  // Address and data go out together; each is dropped at the edge that takes it.
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] exp);
    @(posedge clock);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h000000, d};
    wstrb <= 4'hf;
    {awvalid, wvalid, bready} <= 3'h7;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk_reg({30'h0, bresp}, {30'h0, exp});
  endtask
  task automatic axi_rd(input logic [7:0] idx, input logic [31:0] exp_d, input logic [1:0] exp);
    @(posedge clock);
    araddr <= {idx, 2'h0};
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk_reg(rdata, exp_d);
    chk_reg({30'h0, rresp}, {30'h0, exp});
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // The whole run needs well under ten thousand cycles.
  initial begin
    cyc(40000);
    errors++;
    end_sim();
  end
  initial begin
    cyc(16);
    reset_n <= 1'b1;
    cyc(4);
    for (int i = 0; i < 8; i++) axi_rd(idx_tab[i], 32'h0, `EPIU_RESP_OKAY);
    for (int i = 0; i < 8; i++) axi_wr(idx_tab[i], 8'hff, `EPIU_RESP_OKAY);
    for (int i = 0; i < 8; i++) axi_rd(idx_tab[i], {24'h0, mask_tab[i]}, 2'h0);
    axi_rd(8'h00, 32'h0, `EPIU_RESP_SLVERR);
    axi_wr(8'h00, 8'hff, `EPIU_RESP_SLVERR);
    // Only pin 0, pin 8 and pin 23 are unmasked; pin 1 must stay silent.
    gie <= 1'b1;
    axi_wr(`EPIU_IDX_MLO, 8'h01, `EPIU_RESP_OKAY);
    axi_wr(`EPIU_IDX_MMID, 8'h01, `EPIU_RESP_OKAY);
    axi_wr(`EPIU_IDX_MHI, 8'h80, `EPIU_RESP_OKAY);
    for (int g = 0; g < 4; g++) begin
      pc_cmd <= pc_cmd ^ pin_tab[g];
      cyc(8);
      chk_irq(irq, irq_tab[g]);
      axi_rd(`EPIU_IDX_PCF, {27'h0, irq_tab[g]} >> 2, `EPIU_RESP_OKAY);
      ack <= irq_tab[g];
      cyc(1);
      ack <= 5'h00;
      cyc(1);
      chk_irq(irq, 5'h00);
    end
    pc_cmd <= pc_cmd ^ 24'h000001;
    // The raw pin differs from the filtered copy before the filter catches up.
    cyc(2);
    chk_reg({31'h0, wake}, 32'h1);
    cyc(6);
    chk_reg({31'h0, wake}, 32'h0);
    gie <= 1'b0;
    cyc(1);
    chk_irq(irq, 5'h00);
    gie <= 1'b1;
    axi_wr(`EPIU_IDX_PCF, 8'h01, `EPIU_RESP_OKAY);
    axi_rd(`EPIU_IDX_PCF, 32'h0, `EPIU_RESP_OKAY);
    // Every edge mode on both inputs, each with a falling then a rising move.
    for (int n = 0; n < 2; n++) for (int m = 1; m < 4; m++) begin
      axi_wr(`EPIU_IDX_ESC, 8'(m << (2 * n)), `EPIU_RESP_OKAY);
      for (int lv = 0; lv < 2; lv++) begin
        ext_cmd[n] <= lv[0];
        cyc(8);
        e = (m == 1) || (m == 2 && lv == 0) || (m == 3 && lv == 1);
        chk_irq(irq, e ? 5'(1 << n) : 5'h00);
        axi_rd(`EPIU_IDX_EFL, e ? 32'(1 << n) : 32'h0, `EPIU_RESP_OKAY);
        axi_wr(`EPIU_IDX_EFL, 8'h03, `EPIU_RESP_OKAY);
        chk_irq(irq, 5'h00);
      end
    end
    axi_wr(`EPIU_IDX_ESC, 8'h00, `EPIU_RESP_OKAY);
    ext_cmd <= 2'h0;
    cyc(8);
    chk_irq(irq, 5'h03);
    chk_reg({31'h0, wake}, 32'h1);
    axi_rd(`EPIU_IDX_EFL, 32'h0, `EPIU_RESP_OKAY);
    ext_cmd <= 2'h3;
    cyc(8);
    chk_irq(irq, 5'h00);
    chk_reg({31'h0, wake}, 32'h0);
    end_sim();
  end
endmodule
bind epiu_top epiu_chk chk (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .PC_PIN_I(PC_PIN_I),
  .GIE_I(GIE_I), .ACK_I(ACK_I), .IRQ_O(IRQ_O), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
  .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
  .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
  .RDATA_O(RDATA_O));
`default_nettype wire
